// File: src/power_mode_controller.sv
// Overview of operation
// - Five states; normal default, others by write.
// - Idle bit 0 halts processor after write.
// - Enabled interrupt ends idle, clears idle bit.
// - Reset ending idle restarts at 0x0000.
// - Enabled watchdog reset eventually ends idle.
// - Stop bit 1 halts processor, precision oscillator.
// - Only a reset ends stop.
// - Missing-clock reset ends stop when enabled.
// - Suspend bit 6 gates clock, stops oscillators.
// - Four configurable wake events end suspend.
// - Flags read zero three clocks after wake.
// - Reset-pin glitch ends suspend, sets flag.
// - Suspend exit resumes next instruction, no reset.
// - Sleep gates core power; comparator two-cell only.
// - Config bits: sleep, suspend, clear, flags.
// - Entry refused while enabled flag set.
// - Flags update always, enabled or not.
`include "pmc_defines.svh"

module power_mode_controller
   import pmc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Core register writes
   input wire logic pcr_we,
   input wire logic [7:0] pcr_wdata,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   // Reset sources seen by the controller
   input wire logic watchdog_timer_rst,
   input wire logic missing_clock_detector_rst,
   input wire logic ext_rst,
   input wire logic rst_n_pin,
   // Wake events
   input wire logic irq_pending,
   input wire wake_src_t wake_event,
   input wire logic comparator_level,
   input wire logic two_cell_mode,
   // Status and control outputs
   output logic [7:0] power_control_reg,
   output logic [7:0] power_mgmt_config_reg,
   output power_mode_t mode,
   output gate_ctl_t gate_ctl,
   output logic reset_req,
   output logic [15:0] restart_addr,
   output logic resume_next
);

   // Mode state, wake flags and edge history
   power_mode_t next_mode;
   wake_src_t flags;
   wake_src_t enables;
   wake_src_t next_flags;
   logic pin_reset_wake_flag;
   logic rst_pin_q;
   logic comp_q;
   logic [1:0] holdoff;

   // Edge detectors on pin and comparator
   // Histories reset to the pins' idle levels
   wire pin_fall = rst_pin_q & ~rst_n_pin;
   wire comp_rise = ~comp_q & comparator_level;
   wire any_reset = watchdog_timer_rst | missing_clock_detector_rst | ext_rst;

   // Comparator edge counts in sleep only with a two-cell supply
   wire comp_ok = two_cell_mode | (mode != MODE_SLEEP);

   // Named event inputs, one per configurable source
   // Comparator bit of the event word is unused; its edge comes from the level pin
   wire ev_clock_fail = wake_event.rtc_fail_wake;
   wire ev_alarm = wake_event.rtc_alarm_wake;
   wire ev_port = wake_event.port_match_wake;
   wire ev_comp = comp_rise & comp_ok;

   // Raw event vector in flag bit order
   wire [3:0] raw_ev = {ev_clock_fail, ev_alarm, ev_port, ev_comp};

   // Write decode
   // Mode requests act only in normal, the mode logic ignores them elsewhere; clear and enable writes act in every mode
   wire req_idle = pcr_we & pcr_wdata[`PCR_IDLE_BIT];
   wire req_stop = pcr_we & pcr_wdata[`PCR_STOP_BIT];
   wire req_sleep = cfg_we & cfg_wdata[`PMC_SLEEP_BIT];
   wire req_susp = cfg_we & cfg_wdata[`PMC_SUSPEND_BIT];
   wire req_clear = cfg_we & cfg_wdata[`PMC_CLEAR_BIT];
   wire [3:0] new_en = cfg_wdata[`PMC_FLAGS_MSB:0];

   // Entry is refused while an enabled flag is still set
   // Pin flag blocks too unless the same write clears it
   wire blocked = |(flags & new_en) | (pin_reset_wake_flag & ~req_clear);

   // Wake out of suspend or sleep on enabled event or pin edge
   wire deep = (mode == MODE_SUSPEND) | (mode == MODE_SLEEP);
   wire deep_wake = deep & ((|(raw_ev & enables)) | pin_fall);

   // Flags: events set, clear bit clears, set wins
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
         assign next_flags[gi] = raw_ev[gi] | (flags[gi] & ~req_clear);
      end
   endgenerate

   // Exit conditions; stop has none but reset, handled below
   wire idle_exit = irq_pending;
   wire deep_exit = deep_wake;

   // Mode selection with fixed priority
   // A refused deep entry falls through to stop or idle of the same cycle
   always_comb begin
      next_mode = mode;
      case (mode)
         MODE_NORMAL: begin
            if (req_sleep && !blocked) begin
               next_mode = MODE_SLEEP;
            end else if (req_susp && !blocked) begin
               next_mode = MODE_SUSPEND;
            end else if (req_stop) begin
               next_mode = MODE_STOP;
            end else if (req_idle) begin
               next_mode = MODE_IDLE;
            end
         end
         MODE_IDLE: begin
            if (idle_exit) begin
               next_mode = MODE_NORMAL;
            end
         end
         MODE_STOP: begin
            next_mode = MODE_STOP;
         end
         MODE_SUSPEND, MODE_SLEEP: begin
            if (deep_exit) begin
               next_mode = MODE_NORMAL;
            end
         end
         default: begin
            next_mode = MODE_NORMAL;
         end
      endcase
      // Any reset ends idle or stop and forces normal
      if (any_reset) begin
         next_mode = MODE_NORMAL;
      end
   end

   // Mode register; normal after reset
   // Async reset so the controller always comes up in normal
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= MODE_NORMAL;
      end else begin
         mode <= next_mode;
      end
   end

   // Reset pin history; idles high so reset release shows no false fall
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         rst_pin_q <= 1'b1;
      end else begin
         rst_pin_q <= rst_n_pin;
      end
   end

   // Comparator history; idles low like the comparator output
   // A rise needs one low level first, sampled or loaded by reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         comp_q <= 1'b0;
      end else begin
         comp_q <= comparator_level;
      end
   end

   // Wake flags; an event in the clearing cycle is kept
   // Held even for sources that are not enabled
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   // Pin wake flag; always armed, no enable bit exists for it
   // Set beats clear so a glitch during the clear write is not lost
   wire next_pin_flag = pin_fall | (pin_reset_wake_flag & ~req_clear);
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         pin_reset_wake_flag <= 1'b0;
      end else begin
         pin_reset_wake_flag <= next_pin_flag;
      end
   end

   // Enables follow every configuration write
   // A refused write still loads them; software rewrites on entry
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         enables <= '0;
      end else if (cfg_we) begin
         enables <= new_en;
      end
   end

   // Hold-off count; restarts on every deep wake
   logic [1:0] next_holdoff;
   assign next_holdoff = deep_wake ? `WAKE_HOLDOFF_CYCLES :
                         (holdoff != 2'h0) ? holdoff - 2'h1 : 2'h0;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         holdoff <= 2'h0;
      end else begin
         holdoff <= next_holdoff;
      end
   end

   // Flags read zero for the wake cycle and the hold-off
   wire in_hold = (holdoff != 2'h0) | deep_wake;
   wire [4:0] flag_view = in_hold ? 5'h00 : {pin_reset_wake_flag, next_flags};
   // Mode bits of the config register always read zero
   wire [7:0] next_cfg = {3'h0, flag_view};
   // Control bits follow the mode being entered, so idle exit clears bit 0
   wire [7:0] next_pcr = {6'h00, next_mode == MODE_STOP, next_mode == MODE_IDLE};

   // Power control register view
   // Stop and idle bits read back as active
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         power_control_reg <= 8'h00;
      end else begin
         power_control_reg <= next_pcr;
      end
   end

   // Configuration register view
   // Write-only select bits are never stored
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         power_mgmt_config_reg <= 8'h00;
      end else begin
         power_mgmt_config_reg <= next_cfg;
      end
   end

   // Gating decode from the next mode
   // Registered as one word so no gate leads another by a cycle
   wire deep_next = (next_mode == MODE_SUSPEND) | (next_mode == MODE_SLEEP);
   wire halt_cpu = next_mode != MODE_NORMAL;
   wire clk_gated = deep_next;
   wire prec_osc_off = (next_mode == MODE_STOP) | deep_next;
   wire int_osc_off = deep_next;
   wire core_off = next_mode == MODE_SLEEP;
   gate_ctl_t next_gate;
   assign next_gate = {halt_cpu, clk_gated, prec_osc_off, int_osc_off, core_off};

   // Clock and power gating outputs
   // Halt, clock gate, oscillators and core supply
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gate_ctl <= '0;
      end else begin
         gate_ctl <= next_gate;
      end
   end

   // Reset request lags its source by one clock
   wire next_reset_req = any_reset;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         reset_req <= 1'b0;
      end else begin
         reset_req <= next_reset_req;
      end
   end

   // Restart vector; constant, but registered like every output
   // Program fetch starts here after any reset
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         restart_addr <= `RESET_VECTOR;
      end else begin
         restart_addr <= `RESET_VECTOR;
      end
   end

   // Resume pulse; a reset in the same cycle wins over resume
   wire next_resume = deep_wake & ~any_reset;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         resume_next <= 1'b0;
      end else begin
         resume_next <= next_resume;
      end
   end

endmodule : power_mode_controller

// File: include/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// Power control register bit positions
`define PCR_IDLE_BIT 0
`define PCR_STOP_BIT 1
// Power management configuration register bit positions
`define PMC_SLEEP_BIT 7
`define PMC_SUSPEND_BIT 6
`define PMC_CLEAR_BIT 5
`define PMC_PINRST_BIT 4
`define PMC_FLAGS_MSB 3
// Reset vector
`define RESET_VECTOR 16'h0000
// Flag hold-off after suspend wake, in system clocks
`define WAKE_HOLDOFF_CYCLES 2'h2
`endif

// File: include/pmc_pkg.sv
package pmc_pkg;
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_IDLE,
      MODE_STOP,
      MODE_SUSPEND,
      MODE_SLEEP
   } power_mode_t;

   // Four configurable wake sources, bit order 3..0
   typedef struct packed {
      logic rtc_fail_wake;
      logic rtc_alarm_wake;
      logic port_match_wake;
      logic comparator_wake;
   } wake_src_t;

   // Clock and power gating outputs
   typedef struct packed {
      logic cpu_halt;
      logic sysclk_gate;
      logic precision_osc_off;
      logic internal_osc_off;
      logic core_power_off;
   } gate_ctl_t;
endpackage : pmc_pkg

// File: testbench/pmc_chk.sv
module pmc_chk
   import pmc_pkg::*;
(
   // Watched design ports
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic pcr_we,
   input wire logic [7:0] pcr_wdata,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_wdata,
   input wire logic ext_rst,
   input wire logic watchdog_timer_rst,
   input wire logic missing_clock_detector_rst,
   input wire logic rst_n_pin,
   input wire logic irq_pending,
   input wire logic [7:0] power_mgmt_config_reg,
   input wire power_mode_t mode,
   input wire logic reset_req,
   input wire logic [15:0] restart_addr,
   input wire logic resume_next
);
   // Quiet cycle: no reset source, pin high
   wire logic any_rst = ext_rst | watchdog_timer_rst | missing_clock_detector_rst;
   wire logic quiet = !any_rst && rst_n_pin;
   wire logic in_norm = mode == MODE_NORMAL && quiet && !pcr_we;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_idle_entry:
      assert property (mode == MODE_NORMAL && quiet && pcr_we && pcr_wdata == 8'h01 && !cfg_we
         |=> mode == MODE_IDLE) else $error("idle entry");
   chk_idle_irq:
      assert property (mode == MODE_IDLE && irq_pending && quiet
         |=> mode == MODE_NORMAL) else $error("idle exit");
   chk_stop_hold:
      assert property (mode == MODE_STOP && quiet |=> mode == MODE_STOP) else $error("stop left");
   chk_reset_restart:
      assert property (any_rst |=> reset_req && restart_addr == 16'h0000 && mode == MODE_NORMAL)
         else $error("reset exit");
   chk_sleep_first:
      assert property (in_norm && cfg_we && cfg_wdata[7:6] == 2'b11 && !resume_next
         && !$past(resume_next) && !$past(resume_next, 2) && !power_mgmt_config_reg[4]
         && (power_mgmt_config_reg[3:0] & cfg_wdata[3:0]) == 4'h0 |=> mode == MODE_SLEEP)
         else $error("sleep");
   chk_entry_refused:
      assert property (in_norm && cfg_we && cfg_wdata[7:5] == 3'b010
         && |(power_mgmt_config_reg[3:0] & cfg_wdata[3:0]) |=> mode == MODE_NORMAL)
         else $error("refusal");
   chk_flag_holdoff:
      assert property (resume_next |-> power_mgmt_config_reg == 8'h00 ##1
         power_mgmt_config_reg == 8'h00) else $error("holdoff");
   chk_pin_wake:
      assert property (mode == MODE_SUSPEND && $fell(rst_n_pin) |-> ##[1:3] mode == MODE_NORMAL)
         else $error("pin wake");
endmodule : pmc_chk

bind power_mode_controller pmc_chk pmc_chk_i (.clk_sys, .sys_rst, .pcr_we, .pcr_wdata, .cfg_we,
   .cfg_wdata, .ext_rst, .watchdog_timer_rst, .missing_clock_detector_rst, .rst_n_pin,
   .irq_pending, .power_mgmt_config_reg, .mode, .reset_req, .restart_addr, .resume_next);

// File: testbench/core_model.sv
module core_model (
   // Core write strobes
   input wire logic clk_sys,
   output logic pcr_we,
   output logic [7:0] pcr_wdata,
   output logic cfg_we,
   output logic [7:0] cfg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bus idle from time zero
   initial {pcr_we, pcr_wdata, cfg_we, cfg_wdata} = '0;
   // One-cycle write; clock source and flash bypass assumed set first
   task automatic wr(input logic pcr, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      if (pcr) {pcr_we, pcr_wdata} = {1'b1, d};
      else {cfg_we, cfg_wdata} = {1'b1, d};
      @(posedge clk_sys);
      #1;
      {pcr_we, cfg_we} = 2'b00;
      {pcr_wdata, cfg_wdata} = ~{pcr_wdata, cfg_wdata}; // Stale data never looks valid
   endtask : wr
endmodule : core_model

// File: testbench/power_mode_controller_test.sv
module power_mode_controller_test;
   import pmc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // Design connections
   logic clk_sys = 0, sys_rst = 1, pcr_we, cfg_we, watchdog_timer_rst = 0;
   logic missing_clock_detector_rst = 0, ext_rst = 0, rst_n_pin = 1, irq_pending = 0;
   logic comparator_level = 0, two_cell_mode = 0, reset_req, resume_next;
   logic [7:0] pcr_wdata, cfg_wdata, power_control_reg, power_mgmt_config_reg;
   logic [15:0] restart_addr;
   wake_src_t wake_event = '0;
   power_mode_t mode;
   gate_ctl_t gate_ctl;
   int num_errors = 0, n_compared = 0, cycles = 0;
   power_mode_controller power_mode_controller_i (.clk_sys, .sys_rst, .pcr_we, .pcr_wdata,
      .cfg_we, .cfg_wdata, .watchdog_timer_rst, .missing_clock_detector_rst, .ext_rst,
      .rst_n_pin, .irq_pending, .wake_event, .comparator_level, .two_cell_mode,
      .power_control_reg, .power_mgmt_config_reg, .mode, .gate_ctl, .reset_req,
      .restart_addr, .resume_next);
   core_model core_model_i (.clk_sys, .pcr_we, .pcr_wdata, .cfg_we, .cfg_wdata);
   // 250 MHz clock and a hang limit
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (++cycles == 20000) begin
      num_errors++;
      results();
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : results
   // Idle: interrupt exit, then watchdog reset exit
   task automatic t_idle;
      core_model_i.wr(1, 8'h01);
      cmp({mode, gate_ctl.cpu_halt}, {MODE_IDLE, 1'b1});
      irq_pending = 1;
      tick(1);
      irq_pending = 0;
      cmp({mode, power_control_reg[0]}, {MODE_NORMAL, 1'b0});
      core_model_i.wr(1, 8'h01);
      watchdog_timer_rst = 1;
      tick(1);
      watchdog_timer_rst = 0;
      cmp({reset_req, restart_addr, mode}, {1'b1, 16'h0000, MODE_NORMAL});
   endtask : t_idle
   // Stop ignores interrupts, clock-loss reset ends it
   task automatic t_stop;
      core_model_i.wr(1, 8'h02);
      cmp({mode, gate_ctl.precision_osc_off, power_control_reg[1]}, {MODE_STOP, 2'b11});
      irq_pending = 1;
      tick(3);
      irq_pending = 0;
      cmp(mode, MODE_STOP);
      missing_clock_detector_rst = 1;
      tick(1);
      missing_clock_detector_rst = 0;
      cmp({reset_req, mode}, {1'b1, MODE_NORMAL});
   endtask : t_stop
   // Suspend wake, holdoff, free flags, refusal
   task automatic t_suspend;
      core_model_i.wr(0, 8'h48);
      cmp({mode, gate_ctl.sysclk_gate, gate_ctl.internal_osc_off}, {MODE_SUSPEND, 2'b11});
      wake_event.rtc_alarm_wake = 1;
      tick(1);
      wake_event = 4'h8;
      cmp(mode, MODE_SUSPEND);
      tick(1);
      wake_event = '0;
      cmp({mode, resume_next, power_mgmt_config_reg}, {MODE_NORMAL, 9'h100});
      tick(3);
      wake_event.port_match_wake = 1;
      tick(1);
      wake_event = '0;
      tick(2);
      cmp(power_mgmt_config_reg[3:1], 3'b111);
      core_model_i.wr(0, 8'h42);
      cmp(mode, MODE_NORMAL);
   endtask : t_suspend
   // Reset-pin glitch, then sleep priority and comparator wake
   task automatic t_pin_sleep;
      core_model_i.wr(0, 8'h20);
      core_model_i.wr(0, 8'h40);
      rst_n_pin = 0;
      tick(1);
      rst_n_pin = 1;
      tick(5);
      cmp({mode, power_mgmt_config_reg[4]}, {MODE_NORMAL, 1'b1});
      #15us;
      core_model_i.wr(0, 8'h20);
      core_model_i.wr(0, 8'hC1);
      cmp({mode, gate_ctl.core_power_off}, {MODE_SLEEP, 1'b1});
      comparator_level = 1;
      tick(3);
      cmp(mode, MODE_SLEEP);
      comparator_level = 0;
      two_cell_mode = 1;
      tick(1);
      comparator_level = 1;
      tick(3);
      cmp(mode, MODE_NORMAL);
   endtask : t_pin_sleep
   // Main sequence
   initial begin
      tick(8);
      sys_rst = 0;
      cmp({mode, power_control_reg, reset_req}, {MODE_NORMAL, 9'h000});
      t_idle();
      t_stop();
      t_suspend();
      t_pin_sleep();
      results();
   end
endmodule : power_mode_controller_test
